/* File: src/spm_front.sv */
// Purpose: Command framing, write latch, status register and write guard
// Assumes: Serial clock well below a quarter of clk_sys
// Notes:   Memory read, sleep and identity phases are handed off
`timescale 1ns/100ps
`default_nettype none

module spm_front (
    input  wire logic                       clk_sys,      // 250 MHz clock
    input  wire logic                       reset,        // Sync, high
    input  wire spm_pkg::spm_pins_type      pins,         // Raw pins
    output logic                            data_out,     // Serial out
    output logic                            data_out_en,  // Drive enable
    output logic                            spi_mode3,    // Mode 3 seen
    output logic [7:0]                      protection_status, // Status
    output logic                            mem_wr_valid, // Write pulse
    output spm_pkg::spm_mem_write_type      mem_wr,       // Address, data
    output logic                            mem_wr_refused, // Blocked
    output logic                            handoff_valid, // Other opcode
    output logic [7:0]                      handoff_op    // Its opcode
);
    import spm_pkg::*;

    spm_pins_type  pins_s;
    spm_pins_type  pins_q;
    spm_state_type state;
    spm_state_type next_state;
    logic          in_frame;
    logic [6:0]    rx_shift;
    logic [2:0]    bit_cnt;
    logic [7:0]    tx_shift;
    logic [2:0]    tx_cnt;
    logic          latch;
    logic          pin_guard_enable;
    logic [1:0]    block_guard;
    logic [15:0]   wr_addr;
    logic          addr_second;
    logic          wr_permit;

    spm_sync #(
        .WIDTH     (5),
        .RESET_VAL (PINS_IDLE)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (pins),
        .sync_out (pins_s)
    );

    spm_guard u_guard (
        .clk_sys (clk_sys),
        .reset   (reset),
        .addr    (wr_addr),
        .guard   (block_guard),
        .latch   (latch),
        .permit  (wr_permit)
    );

    // Previous synchronised levels for edge finding
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins_q <= PINS_IDLE;
        end else begin
            pins_q <= pins_s;
        end
    end

    // Edge decode; pause masks clock and select alike
    wire pause_on = !pins_s.pause_n; // [R24]
    wire sel_fall = pins_q.select_n && !pins_s.select_n && !pause_on;
    wire sel_rise = !pins_q.select_n && pins_s.select_n && !pause_on;
    wire clk_rise = in_frame && !pause_on && !pins_q.clk && pins_s.clk;
    wire clk_fall = in_frame && !pause_on && pins_q.clk && !pins_s.clk;
    wire byte_done = clk_rise && (bit_cnt == LAST_BIT); // [R4]
    wire [7:0] rx_byte = {rx_shift, pins_s.data_in};

    // Opcode decode, only on the first byte of a frame
    wire op_done = byte_done && (state == ST_OPCODE); // [R5] [R6]
    wire is_set   = op_done && rx_byte == OP_LATCH_SET;   // [R7]
    wire is_clear = op_done && rx_byte == OP_LATCH_CLEAR; // [R7]
    wire is_fetch = op_done && rx_byte == OP_STAT_FETCH;  // [R7]
    wire is_store = op_done && rx_byte == OP_STAT_STORE;  // [R8]
    wire is_write = op_done && rx_byte == OP_MEM_WRITE;   // [R8]
    wire is_other = op_done && (rx_byte == OP_MEM_READ || // [R8]
                    rx_byte == OP_QUICK_FETCH ||          // [R9]
                    rx_byte == OP_SLEEP ||                // [R9]
                    rx_byte == OP_ID_FETCH ||             // [R9]
                    rx_byte == OP_SN_FETCH);              // [R10]

    // Status store takes effect on its data byte when not refused
    wire store_done  = byte_done && (state == ST_STAT_IN);
    wire pin_block   = pin_guard_enable && !pins_s.protect_n; // [R19]
    wire store_apply = store_done && latch && !pin_block;     // [R20]
    wire data_done   = byte_done && (state == ST_WDATA);
    wire write_end   = sel_rise &&
                       (state == ST_ADDR || state == ST_WDATA); // [R13]

    // Status byte: fixed bits are constants, never stored
    assign protection_status = STAT_FIXED |                  // [R16]
        ({7'h0, pin_guard_enable} << PIN_GUARD_BIT) |
        ({7'h0, block_guard[1]} << GUARD_HI_BIT) |
        ({7'h0, block_guard[0]} << GUARD_LO_BIT) |
        ({7'h0, latch} << LATCH_BIT);

    // Frame state; unknown opcodes fall into the ignore state
    always_comb begin
        next_state = state;
        case (state)
            ST_OPCODE: begin
                if (op_done) begin
                    if (is_fetch) begin
                        next_state = ST_STAT_OUT; // [R15]
                    end else if (is_store) begin
                        next_state = ST_STAT_IN;
                    end else if (is_write) begin
                        next_state = ST_ADDR;
                    end else if (is_other) begin
                        next_state = ST_HANDOFF;
                    end else begin
                        next_state = ST_IGNORE; // [R25] [R6]
                    end
                end
            end
            ST_STAT_IN: begin
                if (store_done) begin
                    next_state = ST_IGNORE; // [R6]
                end
            end
            ST_ADDR: begin
                if (byte_done && addr_second) begin
                    next_state = ST_WDATA;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
    end

    // Select frames every command; pause holds the frame open
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state    <= ST_IDLE;
            in_frame <= 1'b0;
        end else if (sel_rise) begin
            state    <= ST_IDLE; // [R23]
            in_frame <= 1'b0;
        end else if (sel_fall) begin
            state    <= ST_OPCODE; // [R5]
            in_frame <= 1'b1;
        end else begin
            state    <= next_state;
        end
    end

    // Mode is the clock level seen as select falls
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            spi_mode3 <= 1'b0;
        end else if (sel_fall) begin
            spi_mode3 <= pins_s.clk; // [R1]
        end
    end

    // Input shifter on rising edges, MSB first
    always_ff @(posedge clk_sys) begin
        if (reset || sel_fall) begin
            rx_shift <= 7'h00;
            bit_cnt  <= 3'h0;
        end else if (clk_rise) begin
            rx_shift <= rx_byte[6:0]; // [R3] [R4]
            bit_cnt  <= bit_cnt + 3'h1;
        end
    end

    // Write latch: volatile, cleared by power-up reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            latch <= 1'b0; // [R11] [R17]
        end else if (is_set) begin
            latch <= 1'b1; // [R11]
        end else if (is_clear || store_apply || write_end) begin
            latch <= 1'b0; // [R14] [R13] [R12]
        end
    end

    // Guard bits; the latch bit of the data byte is dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_guard_enable <= NV_RESET[2]; // [R17]
            block_guard      <= NV_RESET[1:0];
        end else if (store_apply) begin
            pin_guard_enable <= rx_byte[PIN_GUARD_BIT]; // [R16]
            block_guard      <= rx_byte[GUARD_HI_BIT:GUARD_LO_BIT];
        end
    end

    // Address bytes then data bytes; address wraps at the top
    always_ff @(posedge clk_sys) begin
        if (reset || sel_fall) begin
            wr_addr     <= 16'h0000;
            addr_second <= 1'b0;
        end else if (byte_done && state == ST_ADDR) begin
            wr_addr     <= {wr_addr[7:0], rx_byte};
            addr_second <= 1'b1;
        end else if (data_done) begin
            wr_addr     <= wr_addr + 16'h0001;
        end
    end

    // Memory write strobe, only inside permitted ranges
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_wr_valid   <= 1'b0;
            mem_wr_refused <= 1'b0;
            mem_wr         <= '0;
        end else begin
            mem_wr_valid   <= data_done && wr_permit;  // [R20]
            mem_wr_refused <= data_done && !wr_permit; // [R18]
            if (data_done) begin
                mem_wr <= '{addr: wr_addr, data: rx_byte};
            end
        end
    end

    // Opcodes whose phases live elsewhere are passed on
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            handoff_valid <= 1'b0;
            handoff_op    <= 8'h00;
        end else begin
            handoff_valid <= is_other;
            if (is_other) begin
                handoff_op <= rx_byte; // [R9] [R10]
            end
        end
    end

    // Status out on falling edges; repeats while clocks continue
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_shift <= 8'h00;
            tx_cnt   <= 3'h0;
            data_out <= 1'b0;
        end else if (is_fetch) begin
            tx_shift <= protection_status; // [R15]
            tx_cnt   <= 3'h0;
        end else if (clk_fall && state == ST_STAT_OUT) begin
            data_out <= tx_shift[7]; // [R3] [R4]
            tx_cnt   <= tx_cnt + 3'h1;
            if (tx_cnt == LAST_BIT) begin
                tx_shift <= protection_status;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // Drive only while returning status; released by select or pause
    always_ff @(posedge clk_sys) begin
        if (reset || sel_rise || pause_on || !in_frame) begin
            data_out_en <= 1'b0; // [R23] [R24]
        end else if (clk_fall && state == ST_STAT_OUT) begin
            data_out_en <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // First falling edge of a fetch, line not yet driven
    sequence s_first_fall;
        (state == ST_STAT_OUT && clk_fall && !sel_rise && !data_out_en);
    endsequence

    property p_mode_pick;
        sel_fall |=> (spi_mode3 == $past(pins_s.clk));
    endproperty
    a_mode_pick: assert property (p_mode_pick) // [R1]
        else $error("mode not taken from clock level");

    property p_out_edge;
        $changed(data_out) |-> $past(clk_fall);
    endproperty
    a_out_edge: assert property (p_out_edge) // [R3]
        else $error("data out moved off a falling edge");

    property p_fetch_first_bit;
        s_first_fall |=> (data_out == $past(tx_shift[7]) && data_out_en);
    endproperty
    a_fetch_first_bit: assert property (p_fetch_first_bit) // [R15]
        else $error("status msb not driven first");

    property p_set;
        is_set |=> latch;
    endproperty
    a_set: assert property (p_set) // [R11]
        else $error("latch set command ignored");

    property p_clear;
        is_clear |=> !latch ##1 (latch == $past(is_set));
    endproperty
    a_clear: assert property (p_clear) // [R14]
        else $error("latch clear command ignored");

    property p_store;
        store_apply |=> !latch &&
            pin_guard_enable == $past(rx_byte[PIN_GUARD_BIT]);
    endproperty
    a_store: assert property (p_store) // [R13]
        else $error("status store wrong or latch kept");

    property p_pin_refuse;
        (store_done && pin_block) |=> $stable(block_guard) &&
            $stable(pin_guard_enable);
    endproperty
    a_pin_refuse: assert property (p_pin_refuse) // [R19]
        else $error("status store taken while pin guarded");

    property p_one_op;
        (state == ST_IGNORE && !sel_rise) |=> state == ST_IGNORE;
    endproperty
    a_one_op: assert property (p_one_op) // [R6]
        else $error("second opcode accepted in a frame");

    property p_quiet;
        !in_frame |=> !data_out_en;
    endproperty
    a_quiet: assert property (p_quiet) // [R23]
        else $error("data out driven outside a frame");

    property p_pause;
        pause_on |=> !data_out_en && $stable(state);
    endproperty
    a_pause: assert property (p_pause) // [R24]
        else $error("activity during pause");

    property p_fixed_bits;
        (protection_status & 8'h71) == STAT_FIXED;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) // [R16]
        else $error("fixed status bits wrong");
endmodule // spm_front

`default_nettype wire

/* File: src/spm_guard.sv */
// Purpose: Decide whether a memory byte write may proceed
// Assumes: Latch and guard bits come from the status register
// Notes:   Pure combinational check; the pin guard plays no part here
`timescale 1ns/100ps
`default_nettype none

module spm_guard
    import spm_pkg::*;
(
    input  wire logic        clk_sys,  // System clock, checks only
    input  wire logic        reset,    // Sync reset, checks only
    input  wire logic [15:0] addr,     // Target address
    input  wire logic [1:0]  guard,    // Block guard hi, lo
    input  wire logic        latch,    // Write latch flag
    output logic             permit    // Write may proceed
);
    logic guarded;

    // Upper quarter, upper half or whole array
    assign guarded = (guard == 2'b11) ||
                     (guard == 2'b10 && addr >= HALF_BASE) ||
                     (guard == 2'b01 && addr >= QUARTER_BASE); // [R18]
    assign permit  = latch && !guarded; // [R20]

    property p_guard_range;
        @(posedge clk_sys) disable iff (reset)
        (latch && guard == 2'b01) |-> (permit == (addr < QUARTER_BASE));
    endproperty
    a_guard_range: assert property (p_guard_range) // [R18]
        else $error("quarter guard range wrong");

    property p_no_latch;
        @(posedge clk_sys) disable iff (reset)
        !latch |-> !permit;
    endproperty
    a_no_latch: assert property (p_no_latch) // [R20]
        else $error("write permitted with latch clear");
endmodule // spm_guard

`default_nettype wire

/* File: src/spm_pkg.sv */
// Purpose: Shared constants and types for the serial memory command front end
// Assumes: Pins sampled by clk_sys; 8-bit status byte; 16-bit addresses
// Notes:   Nonvolatile guard bits load their reset value at power-up reset
// Notes on behaviour
// R1: Only modes 0 and 3; clock level at each select fall picks the mode.
// R2: Host presents first bit for the first rising clock edge after select.
// R3: Inputs captured on rising clock edges; outputs change on falling edges.
// R4: All transfers are 8-bit groups, most significant bit first.
// R5: First byte after select falls is the opcode; address and data follow.
// R6: One opcode per select-low period; further bytes never start a command.
// R7: Latch set is 06h, latch clear is 04h, status fetch is 05h.
// R8: Status store is 01h, memory read is 03h, memory write is 02h.
// R9: Quick fetch is 0bh, sleep entry is b9h, identity fetch is 9fh.
// R10: Exactly ten opcodes; serial number fetch is c3h.
// R11: Write latch clear at power-up; set by latch set before any write.
// R12: Status store never changes the write latch flag from its data byte.
// R13: Completing a memory write or status store clears the write latch.
// R14: Latch clear command clears the write latch, disabling all writes.
// R15: After status fetch the device shifts out the current status byte.
// R16: Bit7 pin guard, bits3:2 block guard, bit1 latch; bit6 one, others zero.
// R17: Block guard and pin guard enable are nonvolatile; latch is volatile.
// R18: Guard 00 none, 01 c000h-ffffh, 10 8000h-ffffh, 11 whole array.
// R19: Pin guard enable 1 with protect pin low refuses status store.
// R20: Latch and block guard alone gate memory writes; latch clear refuses all.
// R21: Host keeps the serial clock at or below 40 MHz.
// R22: Host waits the power-up delay before the first select low.
// R23: Select high ignores inputs; data out is driven only while returning data.
// R24: Pause low suspends the operation and ignores clock and select.
// R25: Unknown opcode is ignored with no state change until select rises.

package spm_pkg;

    // Opcodes
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STAT_FETCH  = 8'h05;
    localparam logic [7:0] OP_STAT_STORE  = 8'h01;
    localparam logic [7:0] OP_MEM_READ    = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE   = 8'h02;
    localparam logic [7:0] OP_QUICK_FETCH = 8'h0b;
    localparam logic [7:0] OP_SLEEP       = 8'hb9;
    localparam logic [7:0] OP_ID_FETCH    = 8'h9f;
    localparam logic [7:0] OP_SN_FETCH    = 8'hc3;

    // Status byte layout
    localparam int         PIN_GUARD_BIT = 7;
    localparam int         GUARD_HI_BIT  = 3;
    localparam int         GUARD_LO_BIT  = 2;
    localparam int         LATCH_BIT     = 1;
    localparam logic [7:0] STAT_FIXED    = 8'h40;

    // Reset values and counts
    localparam logic [2:0] NV_RESET  = 3'h0;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [4:0] PINS_IDLE = 5'h13;

    // Guarded ranges
    localparam logic [15:0] QUARTER_BASE = 16'hc000;
    localparam logic [15:0] HALF_BASE    = 16'h8000;

    // Pin bundle, in order select, clock, data, pause, protect
    typedef struct packed {
        logic select_n;
        logic clk;
        logic data_in;
        logic pause_n;
        logic protect_n;
    } spm_pins_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } spm_mem_write_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_STAT_OUT, ST_STAT_IN,
        ST_ADDR, ST_WDATA, ST_HANDOFF, ST_IGNORE
    } spm_state_type;

endpackage

/* File: src/spm_sync.sv */
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Inputs are levels from outside the clk_sys domain
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/100ps
`default_nettype none

module spm_sync #(
    parameter int                WIDTH     = 5,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             reset,     // Sync reset, high
    input  wire logic [WIDTH-1:0] async_in,  // Raw pins
    output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);
    logic [WIDTH-1:0] stage1;

    // Stage one feeds stage two only, to settle metastability
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // spm_sync

`default_nettype wire

/* File: tb/spm_front_test.sv */
// Purpose: Self-checking bench for the serial memory command front end
// Assumes: Host model drives the pins; 250 MHz system clock
// Notes:   Pulses are counted by a monitor and compared per byte
`timescale 1ns/100ps
`default_nettype none

module spm_front_test;
    import spm_pkg::*;

    logic              clk_sys = 1'b0;
    logic              reset = 1'b1;
    spm_pins_type      pins;
    logic              data_out;
    logic              data_out_en;
    logic              spi_mode3;
    logic [7:0]        protection_status;
    logic              mem_wr_valid;
    spm_mem_write_type mem_wr;
    logic              mem_wr_refused;
    logic              handoff_valid;
    logic [7:0]        handoff_op;
    logic [7:0]        rx;
    int                errors = 0;
    int                num_checks = 0;
    int                cycles = 0;
    int                ok_cnt = 0;
    int                ref_cnt = 0;
    int                hand_cnt = 0;

    spm_front u_dut (.clk_sys(clk_sys), .reset(reset), .pins(pins),
        .data_out(data_out), .data_out_en(data_out_en),
        .spi_mode3(spi_mode3), .protection_status(protection_status),
        .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr),
        .mem_wr_refused(mem_wr_refused), .handoff_valid(handoff_valid),
        .handoff_op(handoff_op));

    spm_host u_host (.data_out(data_out), .data_out_en(data_out_en),
        .pins(pins));

    always #2 clk_sys = ~clk_sys;

    // Pulse counters and a ceiling that cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (mem_wr_valid === 1'b1) ok_cnt <= ok_cnt + 1;
        if (mem_wr_refused === 1'b1) ref_cnt <= ref_cnt + 1;
        if (handoff_valid === 1'b1) hand_cnt <= hand_cnt + 1;
        if (cycles == 90000) begin
            errors++;
            end_sim();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Frame of opcode plus optional byte, mode 0
    task automatic frame(input logic [7:0] op, input logic [7:0] b, int n);
        u_host.start(1'b0);
        u_host.shift(op, rx);
        if (n > 1) u_host.shift(b, rx);
        u_host.stop(1'b0);
    endtask

    task automatic t_reset();
        check(protection_status, 8'h40);
        check(data_out_en, 1'b0);
        check(spi_mode3, 1'b0);
        check(mem_wr, 24'h0);
        check({handoff_valid, handoff_op}, 9'h0);
        check({mem_wr_valid, mem_wr_refused, data_out}, 3'h0);
    endtask

    // Pause masks clock edges and drops the data out drive
    task automatic t_pause();
        logic [7:0] st;
        u_host.start(1'b0);
        u_host.hold(1'b1);
        u_host.shift(OP_LATCH_SET, rx);
        u_host.hold(1'b0);
        u_host.shift(OP_STAT_FETCH, rx);
        u_host.shift(8'h00, st);
        u_host.hold(1'b1);
        check(data_out_en, 1'b0);
        u_host.hold(1'b0);
        u_host.stop(1'b0);
        check(st, 8'h40);
        check(protection_status, 8'h40);
    endtask

    // Status fetch in both modes; mode taken at select fall
    task automatic t_modes();
        logic [7:0] st;
        for (int m = 0; m < 2; m++) begin
            u_host.start(m[0]);
            u_host.shift(OP_STAT_FETCH, rx);
            u_host.shift(8'h00, st);
            u_host.stop(m[0]);
            check(spi_mode3, m[0]);
            check(st, 8'h40);
            check(data_out_en, 1'b0);
        end
    endtask

    task automatic t_latch();
        frame(OP_STAT_STORE, 8'h8c, 2);
        check(protection_status, 8'h40);
        frame(OP_LATCH_SET, 8'h00, 1);
        check(protection_status, 8'h42);
        frame(OP_LATCH_CLEAR, 8'h00, 1);
        check(protection_status, 8'h40);
        frame(8'ha5, OP_LATCH_SET, 2);
        check(protection_status, 8'h40);
    endtask

    // Store honours the pin only when pin guard is enabled
    task automatic t_store();
        frame(OP_LATCH_SET, 8'h00, 1);
        frame(OP_STAT_STORE, 8'hff, 2);
        check(protection_status, 8'hcc);
        u_host.pins.protect_n = 1'b0;
        frame(OP_LATCH_SET, 8'h00, 1);
        frame(OP_STAT_STORE, 8'h00, 2);
        check(protection_status, 8'hce);
        u_host.pins.protect_n = 1'b1;
        frame(OP_STAT_STORE, 8'h00, 2);
        check(protection_status, 8'h40);
        u_host.pins.protect_n = 1'b0;
        frame(OP_LATCH_SET, 8'h00, 1);
        frame(OP_STAT_STORE, 8'h04, 2);
        check(protection_status, 8'h44);
        u_host.pins.protect_n = 1'b1;
    endtask

    // Two bytes across a guard boundary, judged byte by byte
    task automatic wr(input logic [15:0] a, input int g, input logic en);
        logic [15:0] ad;
        logic        ok;
        int          o0;
        int          r0;
        if (en) frame(OP_LATCH_SET, 8'h00, 1);
        u_host.start(1'b0);
        u_host.shift(OP_MEM_WRITE, rx);
        u_host.shift(a[15:8], rx);
        u_host.shift(a[7:0], rx);
        for (int k = 0; k < 2; k++) begin
            ad = a + 16'(k);
            ok = en && (g == 0 || (g == 1 && ad < QUARTER_BASE)
                || (g == 2 && ad < HALF_BASE));
            o0 = ok_cnt;
            r0 = ref_cnt;
            u_host.shift(ad[7:0] ^ 8'h5a, rx);
            check(24'(ok_cnt - o0), 24'(ok));
            check(24'(ref_cnt - r0), 24'(!ok));
            if (ok) check(mem_wr, {ad, ad[7:0] ^ 8'h5a});
        end
        u_host.stop(1'b0);
        check(protection_status[1], 1'b0);
    endtask

    task automatic t_guard();
        for (int g = 0; g < 4; g++) begin
            frame(OP_LATCH_SET, 8'h00, 1);
            frame(OP_STAT_STORE, {4'h0, 2'(g), 2'h0}, 2);
            wr(16'h7fff, g, 1'b1);
            wr(16'hbfff, g, 1'b1);
        end
        frame(OP_LATCH_SET, 8'h00, 1);
        frame(OP_STAT_STORE, 8'h00, 2);
        wr(16'h1000, 0, 1'b0);
    endtask

    task automatic t_handoff();
        logic [7:0] ops [5] = '{OP_MEM_READ, OP_QUICK_FETCH, OP_SLEEP,
            OP_ID_FETCH, OP_SN_FETCH};
        int         h0;
        foreach (ops[i]) begin
            h0 = hand_cnt;
            frame(ops[i], 8'h00, 1);
            check(8'(hand_cnt - h0), 8'h01);
            check(handoff_op, ops[i]);
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys); // settle before first select
        t_reset();
        t_modes();
        t_latch();
        t_store();
        t_guard();
        t_handoff();
        t_pause();
        end_sim();
    end
endmodule // spm_front_test
`default_nettype wire

/* File: tb/spm_host.sv */
// Purpose: Host model that drives the serial memory pins
// Assumes: Serial clock of 125 ns period, modes 0 and 3 only
// Notes:   A released data out line reads as the inverse of its last level
`timescale 1ns/100ps
`default_nettype none

module spm_host (
    input  wire logic                data_out,    // Device serial out
    input  wire logic                data_out_en, // Device drive enable
    output var spm_pkg::spm_pins_type pins        // Pins to the device
);
    import spm_pkg::*;

    localparam realtime HALF = 62.5; // 8 MHz serial clock

    logic held_q = 1'b0; // Last level seen on the line

    // Undriven line flips so a stale bit cannot pass as data
    wire line_q = data_out_en ? data_out : ~held_q;

    // Idle pins: not selected, clock low, no pause, no protect
    initial begin
        pins = PINS_IDLE;
    end

    // Clock already at its idle level when select falls
    task automatic start(input logic mode3);
        pins.clk = mode3;
        #HALF;
        pins.select_n = 1'b0;
        #HALF;
    endtask

    // Data set on the falling edge, read back on the rising edge
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.clk = 1'b0;
            pins.data_in = tx[i];
            #HALF;
            pins.clk = 1'b1;
            rx[i] = line_q;
            held_q = line_q;
            #HALF;
        end
    endtask

    // Clock returns to its idle level, then select rises
    task automatic stop(input logic mode3);
        pins.clk = mode3;
        #HALF;
        pins.select_n = 1'b1;
        pins.data_in = ~pins.data_in;
        #HALF;
    endtask

    // Pause moves only while the clock is low
    task automatic hold(input logic on);
        pins.clk = 1'b0;
        #HALF;
        pins.pause_n = !on;
        #HALF;
    endtask
endmodule // spm_host
`default_nettype wire
